/* File: cspsfr_pkg.sv */
// package: addresses, field positions and reset values of the status and power control registers
package cspsfr_pkg;
    // ****************************************************************
    // special function space addresses
    // ****************************************************************
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_STATUS_WORD = 8'hd0;
    localparam logic [7:0] RESET_POWER_CONTROL = 8'h00;
    localparam logic [7:0] RESET_STATUS_WORD = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // ****************************************************************
    // status word fields
    // ****************************************************************
    localparam int STATUS_CARRY = 7;
    localparam int STATUS_AUX_CARRY = 6;
    localparam int STATUS_USER_ZERO = 5;
    localparam int STATUS_BANK_HIGH = 4;
    localparam int STATUS_BANK_LOW = 3;
    localparam int STATUS_OVERFLOW = 2;
    localparam int STATUS_USER_ONE = 1;
    localparam int STATUS_PARITY = 0;
    // ****************************************************************
    // power control fields
    // ****************************************************************
    localparam int PC_BAUD_DOUBLE = 7;
    localparam int PC_SPI_WAKE = 6;
    localparam int PC_EXT0_WAKE = 5;
    localparam int PC_RESERVED = 4;
    localparam int PC_GF_ONE = 3;
    localparam int PC_GF_ZERO = 2;
    localparam int PC_POWERDOWN = 1;
    localparam int PC_IDLE = 0;

    typedef struct packed {
        logic wr;
        logic rd;
        logic bit_op;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
        logic bit_val;
    } cspsfr_req_t;

    typedef struct packed {
        logic carry_flag;
        logic aux_carry_flag;
        logic overflow_flag;
        logic parity;
    } cspsfr_alu_t;
endpackage

/* File: cspsfr_bank_dec.sv */
// one-hot working register bank decoder with registered outputs
`timescale 1ns/1ps
module cspsfr_bank_dec (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // bank select bits
    input wire logic [1:0] i_bank_sel,
    // decoded banks
    output logic [3:0] o_bank_onehot
);
    logic [3:0] onehot_d;
    logic [3:0] onehot_q;

    always_comb begin
        onehot_d = 4'h0;
        onehot_d[i_bank_sel] = 1'b1;
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            onehot_q <= 4'h1;
        end else begin
            onehot_q <= onehot_d;
        end
    end

    assign o_bank_onehot = onehot_q;
endmodule // cspsfr_bank_dec

/* File: cspsfr_regs.sv */
// status word and power control special function registers
//
// Behaviour
// - the two bank select bits of the status word pick working bank 0 to 3 as their binary value.
// - power control sits at 87h, resets to 00h and is reached only as a whole byte.
// - power control bit 7 set doubles the uart baud rate.
// - power control bit 6 enables the spi interrupt as a power-down wake source.
// - power control bit 5 enables external interrupt 0 as a power-down wake source.
// - unmapped addresses hold nothing: reads give 00h and writes change no state.
// - the status word sits at d0h, resets to 00h and is bit addressable.
`timescale 1ns/1ps
module cspsfr_regs (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // core direct-address access
    input wire cspsfr_pkg::cspsfr_req_t i_req,
    output logic [7:0] o_rdata,
    // alu flag update from the core
    input wire logic i_alu_we,
    input wire cspsfr_pkg::cspsfr_alu_t i_alu,
    // wake events
    input wire logic i_spi_irq,
    input wire logic i_ext0_irq,
    input wire logic i_wake_clear,
    // controls to the rest of the chip
    output logic [1:0] o_bank_sel,
    output logic [3:0] o_bank_onehot,
    output logic o_baud_double,
    output logic o_powerdown,
    output logic o_idle,
    output logic o_wake
);
    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] pwrctl_q;
    logic [7:0] pwrctl_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic wake_q;
    logic wake_d;
    logic spi_s1_q;
    logic spi_s2_q;
    logic ext_s1_q;
    logic ext_s2_q;

    // ****************************************************************
    // decoded strobes
    // ****************************************************************
    logic status_wr;
    logic pwrctl_wr;
    logic spi_wake;
    logic ext_wake;
    logic wake_event;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic hit_status(input logic [7:0] addr);
        return addr == cspsfr_pkg::ADDR_STATUS_WORD;
    endfunction

    function automatic logic hit_power(input logic [7:0] addr);
        return addr == cspsfr_pkg::ADDR_POWER_CONTROL;
    endfunction

    function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] sel, input logic b);
        logic [7:0] r;
        r = v;
        r[sel] = b;
        return r;
    endfunction

    // the reserved bit never stores a one, so software cannot park state in it
    function automatic logic [7:0] power_mask(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        r[cspsfr_pkg::PC_RESERVED] = 1'b0;
        return r;
    endfunction

    // ****************************************************************
    // access decode
    // ****************************************************************
    always_comb begin
        status_wr = i_req.wr && hit_status(i_req.addr);
        // bit stores to power control are dropped: the byte is not bit addressable
        pwrctl_wr = i_req.wr && !i_req.bit_op && hit_power(i_req.addr);
        spi_wake = pwrctl_q[cspsfr_pkg::PC_SPI_WAKE] && spi_s2_q;
        ext_wake = pwrctl_q[cspsfr_pkg::PC_EXT0_WAKE] && ext_s2_q;
        wake_event = pwrctl_q[cspsfr_pkg::PC_POWERDOWN] && (spi_wake || ext_wake);
    end

    // ****************************************************************
    // status word
    // ****************************************************************
    always_comb begin
        status_d = status_q;
        if (i_alu_we) begin
            status_d[cspsfr_pkg::STATUS_CARRY] = i_alu.carry_flag;
            status_d[cspsfr_pkg::STATUS_AUX_CARRY] = i_alu.aux_carry_flag;
            status_d[cspsfr_pkg::STATUS_OVERFLOW] = i_alu.overflow_flag;
        end
        // software store after the carry, aux carry and overflow flags so an explicit store wins over those three
        if (status_wr) begin
            if (i_req.bit_op) begin
                status_d = set_bit(status_d, i_req.bit_sel, i_req.bit_val);
            end else begin
                status_d = i_req.wdata;
            end
        end
        // parity follows the core flag, which wins over a store in the same cycle; a real core derives it from the accumulator
        if (i_alu_we) begin
            status_d[cspsfr_pkg::STATUS_PARITY] = i_alu.parity;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            status_q <= cspsfr_pkg::RESET_STATUS_WORD;
        end else begin
            status_q <= status_d;
        end
    end

    // ****************************************************************
    // power control
    // ****************************************************************
    always_comb begin
        pwrctl_d = pwrctl_q;
        if (pwrctl_wr) begin
            pwrctl_d = power_mask(i_req.wdata);
        end
        // a wake ends power-down even against a store in the same cycle
        if (wake_event) begin
            pwrctl_d[cspsfr_pkg::PC_POWERDOWN] = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pwrctl_q <= cspsfr_pkg::RESET_POWER_CONTROL;
        end else begin
            pwrctl_q <= pwrctl_d;
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    always_comb begin
        rdata_d = rdata_q;
        // reads return the next value so a read beside a store sees the new byte
        if (i_req.rd) begin
            if (hit_status(i_req.addr)) begin
                rdata_d = status_d;
            end else if (hit_power(i_req.addr) && !i_req.bit_op) begin
                rdata_d = pwrctl_d;
            end else begin
                rdata_d = cspsfr_pkg::UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ****************************************************************
    // wake flag
    // ****************************************************************
    always_comb begin
        wake_d = wake_q;
        if (i_wake_clear) begin
            wake_d = 1'b0;
        end
        // set wins over a clear in the same cycle so no wake is lost
        if (wake_event) begin
            wake_d = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_d;
        end
    end

    // ****************************************************************
    // interrupt synchronisers
    // ****************************************************************
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            spi_s1_q <= 1'b0;
            spi_s2_q <= 1'b0;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
        end else begin
            spi_s1_q <= i_spi_irq;
            spi_s2_q <= spi_s1_q;
            ext_s1_q <= i_ext0_irq;
            ext_s2_q <= ext_s1_q;
        end
    end

    // ****************************************************************
    // bank decode and outputs
    // ****************************************************************
    // fed from the next value so the one-hot flops move on the same edge as the select bits
    cspsfr_bank_dec u_bank_dec (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_bank_sel(status_d[cspsfr_pkg::STATUS_BANK_HIGH:cspsfr_pkg::STATUS_BANK_LOW]),
        .o_bank_onehot(o_bank_onehot)
    );

    assign o_rdata = rdata_q;
    assign o_bank_sel = status_q[cspsfr_pkg::STATUS_BANK_HIGH:cspsfr_pkg::STATUS_BANK_LOW];
    assign o_baud_double = pwrctl_q[cspsfr_pkg::PC_BAUD_DOUBLE];
    assign o_powerdown = pwrctl_q[cspsfr_pkg::PC_POWERDOWN];
    assign o_idle = pwrctl_q[cspsfr_pkg::PC_IDLE];
    assign o_wake = wake_q;
endmodule // cspsfr_regs

/* File: cspsfr_properties.sv */
// checker: port properties of the status word and power control registers
`timescale 1ns/1ps
module cspsfr_properties (
    // core side
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire cspsfr_pkg::cspsfr_req_t i_req,
    input wire logic [7:0] o_rdata,
    input wire logic i_alu_we,
    input wire cspsfr_pkg::cspsfr_alu_t i_alu,
    // wake and controls
    input wire logic i_spi_irq,
    input wire logic i_ext0_irq,
    input wire logic i_wake_clear,
    input wire logic [1:0] o_bank_sel,
    input wire logic [3:0] o_bank_onehot,
    input wire logic o_baud_double,
    input wire logic o_powerdown,
    input wire logic o_idle,
    input wire logic o_wake
);
    // ****
    // properties
    // ****
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);
    wire logic m87 = i_req.addr == 8'h87;
    wire logic mu = !m87 && i_req.addr != 8'hd0;
    wire logic pw = i_req.wr && !i_req.bit_op && m87;
    // wake enables are not on the ports, so they are mirrored here
    logic [1:0] wen_q;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn)
            wen_q <= 2'h0;
        else if (pw)
            wen_q <= i_req.wdata[6:5];
    end
    a_bank_decode: assert property (o_bank_onehot == (4'h1 << o_bank_sel))
        else $error("bank decode");
    a_pc_write: assert property (pw |=> o_baud_double == $past(i_req.wdata[7]) && o_idle == $past(i_req.wdata[0]))
        else $error("power control write");
    a_pc_bit_wr: assert property (i_req.wr && i_req.bit_op && m87 |=> $stable(o_baud_double) && $stable(o_idle))
        else $error("power control bit write");
    a_pc_read: assert property (i_req.rd && !i_req.bit_op && m87 |=> o_rdata[7] == o_baud_double && !o_rdata[4])
        else $error("power control read");
    a_unmapped_rd: assert property (i_req.rd && mu |=> o_rdata == cspsfr_pkg::UNMAPPED_READ)
        else $error("unmapped read");
    a_status_bit_wr: assert property (i_req.wr && i_req.bit_op && !m87 && !mu && i_req.bit_sel == 3'h3
        |=> o_bank_sel[0] == $past(i_req.bit_val))
        else $error("status bit write");
    a_spi_wake: assert property ((o_powerdown && wen_q[1] && i_spi_irq)[*3] |=> o_wake)
        else $error("spi wake");
    a_ext_wake: assert property ((o_powerdown && wen_q[0] && i_ext0_irq)[*3] |=> o_wake)
        else $error("ext wake");
    a_wake_ends_powerdown: assert property ($rose(o_wake) |-> $fell(o_powerdown))
        else $error("wake without powerdown exit");
    c_wake: cover property (o_wake);
    c_bank3: cover property (o_bank_onehot == 4'h8);
    c_pc_write: cover property (pw);
endmodule // cspsfr_properties
bind cspsfr_regs cspsfr_properties cspsfr_properties_i (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_req(i_req), .o_rdata(o_rdata), .i_alu_we(i_alu_we), .i_alu(i_alu), .i_spi_irq(i_spi_irq),
    .i_ext0_irq(i_ext0_irq), .i_wake_clear(i_wake_clear), .o_bank_sel(o_bank_sel),
    .o_bank_onehot(o_bank_onehot), .o_baud_double(o_baud_double), .o_powerdown(o_powerdown),
    .o_idle(o_idle), .o_wake(o_wake));

/* File: tb_top.sv */
// testbench: directed scenarios for the status word and power control registers
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cspsfr_pkg::cspsfr_req_t rq = '0;
    cspsfr_pkg::cspsfr_alu_t alu = '0;
    logic alu_we = 1'b0;
    logic spi = 1'b0;
    logic ext = 1'b0;
    logic wclr = 1'b0;
    logic [7:0] rdata;
    logic [3:0] oh;
    logic [1:0] bsel;
    logic baud, pwr_down, idle, wake;
    int bad_count = 0;
    int n_checks = 0;
    wire logic [7:0] ctl = {baud, pwr_down, idle, wake, oh};
    always #25 clk = ~clk;
    cspsfr_regs cspsfr_regs_i (.i_core_clk(clk), .i_resetn(rst_n), .i_req(rq), .o_rdata(rdata),
        .i_alu_we(alu_we), .i_alu(alu), .i_spi_irq(spi), .i_ext0_irq(ext), .i_wake_clear(wclr),
        .o_bank_sel(bsel), .o_bank_onehot(oh), .o_baud_double(baud), .o_powerdown(pwr_down),
        .o_idle(idle), .o_wake(wake));
    // ****
    // tasks
    // ****
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    // request held for exactly one taking edge
    task automatic acc(input logic w, r, b, input logic [7:0] a, input logic [2:0] s, input logic [7:0] d);
        @(posedge clk);
        rq <= '{w, r, b, a, s, d, 1'b0};
        @(posedge clk);
        rq <= '0;
        #1;
    endtask
    task automatic rd8(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, 1'b1, 1'b0, a, 3'h0, 8'h00);
        chk(rdata, e);
    endtask
    task automatic t_wake(input logic [7:0] en, input logic s, input logic e, input logic [7:0] x);
        acc(1'b1, 1'b0, 1'b0, 8'h87, 3'h0, en | 8'h02);
        @(posedge clk);
        spi <= s;
        ext <= e;
        for (int i = 0; i < 8 && wake !== 1'b1; i++)
            @(negedge clk);
        #1;
        chk(ctl, x);
        @(posedge clk);
        {spi, ext, wclr} <= 3'h1;
        @(posedge clk);
        wclr <= 1'b0;
        #1;
        chk(ctl, x & 8'hef);
        acc(1'b1, 1'b0, 1'b0, 8'h87, 3'h0, 8'h00);
    endtask
    task automatic t_reset_values;
        chk(ctl, 8'h01);
        rd8(8'h87, 8'h00);
        rd8(8'hd0, 8'h00);
        $display("end reset values");
    endtask
    task automatic t_status;
        for (int b = 0; b < 4; b++) begin
            acc(1'b1, 1'b0, 1'b0, 8'hd0, 3'h0, 8'(b << 3));
            chk(ctl, 8'(1 << b));
            chk({6'h00, bsel}, 8'(b));
            rd8(8'hd0, 8'(b << 3));
        end
        acc(1'b1, 1'b0, 1'b1, 8'hd0, 3'h3, 8'h00);
        chk(ctl, 8'h04);
        @(posedge clk);
        alu <= '{1'b1, 1'b0, 1'b1, 1'b1};
        alu_we <= 1'b1;
        @(posedge clk);
        alu_we <= 1'b0;
        rd8(8'hd0, 8'h95);
        $display("end status word");
    endtask
    task automatic t_power;
        acc(1'b1, 1'b0, 1'b0, 8'h87, 3'h0, 8'hff);
        chk(ctl, 8'he4);
        rd8(8'h87, 8'hef);
        acc(1'b1, 1'b0, 1'b1, 8'h87, 3'h7, 8'h00);
        chk(ctl, 8'he4);
        acc(1'b0, 1'b1, 1'b1, 8'h87, 3'h7, 8'h00);
        chk(rdata, 8'h00);
        acc(1'b1, 1'b0, 1'b0, 8'h87, 3'h0, 8'h0c);
        rd8(8'h87, 8'h0c);
        acc(1'b1, 1'b0, 1'b0, 8'h88, 3'h0, 8'hff);
        rd8(8'h88, cspsfr_pkg::UNMAPPED_READ);
        rd8(8'h87, 8'h0c);
        $display("end power control");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_values;
        t_status;
        t_power;
        t_wake(8'h40, 1'b1, 1'b0, 8'h14);
        t_wake(8'h20, 1'b0, 1'b1, 8'h14);
        t_wake(8'h40, 1'b0, 1'b1, 8'h44);
        t_wake(8'h20, 1'b1, 1'b0, 8'h44);
        $display("end wake");
        final_report;
    end
    // whole run is about a hundred cycles
    initial begin
        #100000;
        bad_count++;
        final_report;
    end
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
endmodule // tb_top
